// *** rtl/flash_guard_defs.svh ***
// Constants for the boot flash self-program guard: boundaries, lock encodings,
// register offsets, field positions and timing counts.
// Assumes word addressing of a 64K-word flash; included by bare name.
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

`define FG_ADDR_W            16
`define FG_STALL_START       16'hF000
`define FG_BOOT_START_0      16'hF000
`define FG_BOOT_START_1      16'hF800
`define FG_BOOT_START_2      16'hFC00
`define FG_BOOT_START_3      16'hFE00
`define FG_LOCK_OPEN         2'h3
`define FG_LOCK_NO_STORE     2'h2
`define FG_LOCK_ALL          2'h0
`define FG_LOCK_NO_LOAD      2'h1
`define FG_REG_CTRL          4'h0
`define FG_REG_STATUS        4'h1
`define FG_REG_LOCKS         4'h2
`define FG_CTRL_STORE_EN     0
`define FG_CTRL_BUSY_CLR     1
`define FG_STAT_BUSY         0
`define FG_STAT_STORE_EN     1
`define FG_STAT_STALL        2
`define FG_STAT_BLOCKED      3
`define FG_OP_TIME_NS        4000
`define FG_CLK_PERIOD_NS     20
`define FG_OP_CYCLES         (`FG_OP_TIME_NS / `FG_CLK_PERIOD_NS)
`define FG_ARM_CYCLES        4
`define FG_BLANK_WORD        16'hFFFF

`endif

// *** rtl/flash_guard_pkg.sv ***
// Types shared by the flash guard and its address classifier.
// Assumes the constants header is available on the include path.
package flash_guard_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_ERASE,
    OP_WRITE,
    OP_LOCK_SET
  } prog_op_t;

  typedef struct packed {
    logic is_boot;
    logic is_stall;
  } addr_class_t;

  typedef struct packed {
    logic       valid;
    prog_op_t   op;
    logic [15:0] addr;
    logic [15:0] code_pc;
    logic [3:0]  lock_val;
  } store_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] code_pc;
  } load_req_t;
endpackage

// *** rtl/addr_classifier.sv ***
// Classifies a flash word address into boot/application and stalling/concurrent.
// Assumes the boundary select is a stable fuse level.
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module addr_classifier
  import flash_guard_pkg::*;
(
  input  wire logic [15:0] addr_in,
  input  wire logic [1:0]  boot_size_fuses_in,
  output addr_class_t      cls_out
);
  logic [15:0] boot_start;

  // Every boot start is at or above the stalling start, so boot code never stalls itself out.
  assign boot_start = (boot_size_fuses_in == 2'h0) ? `FG_BOOT_START_0 :
                      (boot_size_fuses_in == 2'h1) ? `FG_BOOT_START_1 :
                      (boot_size_fuses_in == 2'h2) ? `FG_BOOT_START_2 : `FG_BOOT_START_3;
  assign cls_out.is_boot  = (addr_in >= boot_start);
  assign cls_out.is_stall = (addr_in >= `FG_STALL_START);
endmodule

// *** rtl/flash_guard.sv ***
// Self-programming guard for on-chip program flash.
// Assumes a CPU that presents store and load requests for one cycle each.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module flash_guard
  import flash_guard_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [1:0]  boot_size_fuses_in,
  input  wire logic        vectors_in_boot_in,
  input  wire logic [1:0]  general_lock_in,
  input  wire logic        chip_erase_in,
  input  wire logic [3:0]  ext_lock_prog_in,
  input  wire logic        ext_lock_prog_we_in,
  input  store_req_t       store_in,
  input  load_req_t        load_in,
  input  wire logic [15:0] flash_rdata_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_we_in,
  input  wire logic        reg_re_in,
  output logic [7:0]       reg_rdata_out,
  output logic             cpu_halt_out,
  output logic             irq_mask_out,
  output logic             flash_prog_out,
  output prog_op_t         flash_op_out,
  output logic [15:0]      flash_addr_out,
  output logic [15:0]      load_data_out,
  output logic             load_valid_out,
  output logic             load_denied_out,
  output logic             prog_done_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} state_t;

  localparam logic [15:0] OP_CYCLES  = 16'(`FG_OP_CYCLES);
  localparam logic [2:0]  ARM_CYCLES = 3'(`FG_ARM_CYCLES);

  state_t      state_r, state_nxt;
  logic [15:0] count_r;
  logic [2:0]  arm_r;
  logic        store_en_r;
  logic        busy_flag_r;
  logic        stall_op_r;
  logic [1:0]  app_lock_r;
  logic [1:0]  boot_lock_r;
  logic [7:0]  reg_rdata_r;
  logic        halt_r, irqm_r, prog_r, done_r;
  prog_op_t    op_r;
  logic [15:0] faddr_r, ldata_r;
  logic        lvalid_r, ldenied_r;

  addr_class_t st_cls, st_pc_cls, ld_cls, ld_pc_cls, pc_cls;

  addr_classifier u_st (.addr_in(store_in.addr), .boot_size_fuses_in(boot_size_fuses_in), .cls_out(st_cls));
  addr_classifier u_sp (.addr_in(store_in.code_pc), .boot_size_fuses_in(boot_size_fuses_in), .cls_out(st_pc_cls));
  addr_classifier u_ld (.addr_in(load_in.addr), .boot_size_fuses_in(boot_size_fuses_in), .cls_out(ld_cls));
  addr_classifier u_lp (.addr_in(load_in.code_pc), .boot_size_fuses_in(boot_size_fuses_in), .cls_out(ld_pc_cls));
  assign pc_cls = ld_pc_cls;

  function automatic logic store_blocked(input logic [1:0] lk);
    store_blocked = (lk == `FG_LOCK_NO_STORE) || (lk == `FG_LOCK_ALL);
  endfunction

  function automatic logic load_blocked(input logic [1:0] lk);
    load_blocked = (lk == `FG_LOCK_NO_LOAD) || (lk == `FG_LOCK_ALL);
  endfunction

  // The general lock level is deliberately not an input to any decision below.
  wire unused_glock = ^general_lock_in;

  wire ctrl_wr   = reg_we_in && (reg_addr_in == `FG_REG_CTRL);
  wire arm_write = ctrl_wr && reg_wdata_in[`FG_CTRL_STORE_EN];
  wire armed     = (arm_r != 3'h0) || arm_write;
  wire busy_clr  = ctrl_wr && reg_wdata_in[`FG_CTRL_BUSY_CLR];

  // Only boot code may start programming, to any address outside a store-locked section.
  wire from_boot  = st_pc_cls.is_boot;
  wire tgt_lock   = st_cls.is_boot ? store_blocked(boot_lock_r) : store_blocked(app_lock_r);
  wire is_lock_op = (store_in.op == OP_LOCK_SET);
  wire store_ok   = store_in.valid && armed && from_boot && (state_r == ST_IDLE) && store_en_r
                    && (is_lock_op || ((store_in.op != OP_NONE) && !tgt_lock));
  wire start_prog = store_ok && !is_lock_op;
  wire lock_set   = store_ok && is_lock_op;
  wire op_end     = (state_r == ST_BUSY) && (count_r == 16'h0001);

  // Cross-section loads are refused per the lock of the target section.
  wire cross_ld  = (ld_cls.is_boot != ld_pc_cls.is_boot);
  wire lock_deny = cross_ld && (ld_cls.is_boot ? load_blocked(boot_lock_r) : load_blocked(app_lock_r));
  wire rww_deny  = busy_flag_r && !ld_cls.is_stall;
  wire ld_deny   = lock_deny || rww_deny;

  // Interrupts are masked while code runs in the section opposite the vectors under a load lock.
  wire irqm_nxt = (!pc_cls.is_boot && vectors_in_boot_in && load_blocked(app_lock_r)) ||
                  (pc_cls.is_boot && !vectors_in_boot_in && load_blocked(boot_lock_r));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_prog) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (op_end) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  wire [7:0] status_word = {4'h0, (busy_flag_r && state_r == ST_BUSY), halt_r, store_en_r, busy_flag_r};
  wire [7:0] rd_mux = (reg_addr_in == `FG_REG_CTRL)   ? {7'h00, store_en_r} :
                      (reg_addr_in == `FG_REG_STATUS) ? status_word :
                      (reg_addr_in == `FG_REG_LOCKS)  ? {4'h0, boot_lock_r, app_lock_r} : 8'h00;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      count_r <= 16'h0000;
      stall_op_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_prog) begin
        count_r    <= OP_CYCLES;
        stall_op_r <= st_cls.is_stall;
      end else if (state_r == ST_BUSY) begin
        count_r <= count_r - 16'h0001;
      end
    end
  end

  // A store taken on the last edge of the window keeps the enable up until its operation ends.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arm_r      <= 3'h0;
      store_en_r <= 1'b0;
    end else begin
      if (arm_write) begin
        arm_r <= ARM_CYCLES;
      end else if (arm_r != 3'h0) begin
        arm_r <= arm_r - 3'h1;
      end
      if (op_end || lock_set) begin
        store_en_r <= 1'b0;
      end else if (arm_write) begin
        store_en_r <= 1'b1;
      end else if (arm_r == 3'h1 && state_r == ST_IDLE && !start_prog) begin
        store_en_r <= 1'b0;
      end
    end
  end

  // Set wins over software clear; the flag stays up until software clears it.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_flag_r <= 1'b0;
    end else if (start_prog || state_r == ST_BUSY) begin
      busy_flag_r <= 1'b1;
    end else if (busy_clr) begin
      busy_flag_r <= 1'b0;
    end
  end

  // Locks may only move toward programmed (zero); only chip erase or reset reopens them.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      app_lock_r  <= `FG_LOCK_OPEN;
      boot_lock_r <= `FG_LOCK_OPEN;
    end else if (chip_erase_in) begin
      app_lock_r  <= `FG_LOCK_OPEN;
      boot_lock_r <= `FG_LOCK_OPEN;
    end else if (lock_set) begin
      app_lock_r  <= app_lock_r & store_in.lock_val[1:0];
      boot_lock_r <= boot_lock_r & store_in.lock_val[3:2];
    end else if (ext_lock_prog_we_in) begin
      app_lock_r  <= app_lock_r & ext_lock_prog_in[1:0];
      boot_lock_r <= boot_lock_r & ext_lock_prog_in[3:2];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      halt_r  <= 1'b0;
      prog_r  <= 1'b0;
      op_r    <= OP_NONE;
      faddr_r <= 16'h0000;
      done_r  <= 1'b0;
      irqm_r  <= 1'b0;
    end else begin
      halt_r <= (start_prog && st_cls.is_stall) || (state_nxt == ST_BUSY && stall_op_r && !start_prog);
      prog_r <= (state_nxt == ST_BUSY);
      if (start_prog) begin
        op_r    <= store_in.op;
        faddr_r <= store_in.addr;
      end
      done_r <= op_end;
      irqm_r <= irqm_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ldata_r     <= 16'h0000;
      lvalid_r    <= 1'b0;
      ldenied_r   <= 1'b0;
      reg_rdata_r <= 8'h00;
    end else begin
      lvalid_r    <= load_in.valid && !ld_deny;
      ldenied_r   <= load_in.valid && ld_deny;
      ldata_r     <= (load_in.valid && !ld_deny) ? flash_rdata_in : `FG_BLANK_WORD;
      reg_rdata_r <= reg_re_in ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_out   = reg_rdata_r;
  assign cpu_halt_out    = halt_r;
  assign irq_mask_out    = irqm_r;
  assign flash_prog_out  = prog_r;
  assign flash_op_out    = op_r;
  assign flash_addr_out  = faddr_r;
  assign load_data_out   = ldata_r;
  assign load_valid_out  = lvalid_r;
  assign load_denied_out = ldenied_r;
  assign prog_done_out   = done_r;

  property p_app_store_ignored;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (store_in.valid && !st_pc_cls.is_boot && state_r == ST_IDLE) |=> !prog_r;
  endproperty
  a_app_store_ignored: assert property (p_app_store_ignored) else $error("store from application started programming");

  property p_boot_store_starts;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      start_prog |=> prog_r && faddr_r == $past(store_in.addr);
  endproperty
  a_boot_store_starts: assert property (p_boot_store_starts) else $error("accepted store did not start");

  property p_boot_in_stall;
    @(posedge ref_clk_in) disable iff (!rst_n_in) ld_cls.is_boot |-> ld_cls.is_stall;
  endproperty
  a_boot_in_stall: assert property (p_boot_in_stall) else $error("boot address outside stalling region");

  property p_stall_halt;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (start_prog && st_cls.is_stall) |=> halt_r [*8];
  endproperty
  a_stall_halt: assert property (p_stall_halt) else $error("CPU not halted for stalling-region programming");

  property p_rww_no_halt;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (start_prog && !st_cls.is_stall) |=> !halt_r;
  endproperty
  a_rww_no_halt: assert property (p_rww_no_halt) else $error("CPU halted for concurrent-region programming");

  property p_rww_read_blocked;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (load_in.valid && prog_r && !ld_cls.is_stall) |=> ldenied_r && !lvalid_r;
  endproperty
  a_rww_read_blocked: assert property (p_rww_read_blocked) else $error("concurrent-region read served during programming");

  property p_busy_reads_one;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (reg_re_in && reg_addr_in == `FG_REG_STATUS && prog_r) |=> reg_rdata_out[`FG_STAT_BUSY];
  endproperty
  a_busy_reads_one: assert property (p_busy_reads_one) else $error("busy flag read zero while blocked");

  property p_locks_monotone;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !chip_erase_in |=> ((app_lock_r & ~$past(app_lock_r)) == 2'h0) && ((boot_lock_r & ~$past(boot_lock_r)) == 2'h0);
  endproperty
  a_locks_monotone: assert property (p_locks_monotone) else $error("lock field unprogrammed without chip erase");

  property p_locked_store;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (store_in.valid && !is_lock_op && tgt_lock && state_r == ST_IDLE) |=> !prog_r;
  endproperty
  a_locked_store: assert property (p_locked_store) else $error("locked section was programmed");

  property p_done_clears_en;
    @(posedge ref_clk_in) disable iff (!rst_n_in) op_end |=> !store_en_r && prog_done_out;
  endproperty
  a_done_clears_en: assert property (p_done_clears_en) else $error("store enable not cleared at completion");

  property p_halt_whole_op;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (prog_r && stall_op_r) |-> halt_r;
  endproperty
  a_halt_whole_op: assert property (p_halt_whole_op) else $error("CPU ran during stalling-region operation");

  property p_halt_in_op;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      halt_r |-> prog_r;
  endproperty
  a_halt_in_op: assert property (p_halt_in_op) else $error("CPU halted with no operation running");

  property p_busy_holds;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ((busy_flag_r && !busy_clr) || state_r == ST_BUSY) |=> busy_flag_r;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy flag dropped without a clear");

  property p_en_held_in_op;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      prog_r |-> store_en_r;
  endproperty
  a_en_held_in_op: assert property (p_en_held_in_op) else $error("store enable dropped during operation");

  property p_denied_blank;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ldenied_r |-> (ldata_r == `FG_BLANK_WORD) && !lvalid_r;
  endproperty
  a_denied_blank: assert property (p_denied_blank) else $error("denied load returned contents");

  c_rww_prog: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) start_prog && !st_cls.is_stall);
  c_stall_prog: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) start_prog && st_cls.is_stall);
  c_lock_set: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) lock_set);
  c_deny_load: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) load_in.valid && lock_deny);
endmodule

// *** verif/cpu_core_model.sv ***
// CPU core model: issues one-cycle store and load requests and returns flash words.
// Assumes the bench calls its tasks from just after a rising edge of the shared clock.
`timescale 1ns/1ps
module cpu_core_model
  import flash_guard_pkg::*;
(
  input  wire logic   clk_in,
  output store_req_t  store_out,
  output load_req_t   load_out,
  output logic [15:0] flash_rdata_out
);
  logic [15:0] noise_r;

  initial begin
    store_out = '0;
    load_out = '0;
    noise_r = 16'h0000;
  end

  // Idle data lines keep changing so a stale word can never pass for a read.
  always @(posedge clk_in) begin
    noise_r <= noise_r + 16'h1357;
  end

  assign flash_rdata_out = load_out.valid ? ~load_out.addr : noise_r;

  // The bench arms the store enable first, so the store lands in the window.
  task automatic do_store(input prog_op_t op, input logic [15:0] a, input logic [15:0] pc, input logic [3:0] lv);
    @(posedge clk_in);
    store_out <= '{1'b1, op, a, pc, lv};
    @(posedge clk_in);
    store_out <= '{1'b0, OP_NONE, ~a, pc, ~lv};
  endtask

  // The executing address stays put after a load, as a running core would keep it.
  task automatic do_load(input logic [15:0] a, input logic [15:0] pc);
    @(posedge clk_in);
    load_out <= '{1'b1, a, pc};
    @(posedge clk_in);
    load_out <= '{1'b0, ~a, pc};
  endtask
endmodule

// *** verif/flash_guard_test.sv ***
// Self-checking bench for the flash self-program guard.
// Assumes the constants header on the include path and the CPU model beside it.
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module flash_guard_test
  import flash_guard_pkg::*;
;
  logic        ref_clk_in, rst_n_in, vec_boot, chip_erase, ext_we, reg_we, reg_re;
  logic [1:0]  fuses, gen_lock;
  logic [3:0]  ext_lock, reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        cpu_halt, irq_mask, flash_prog, load_valid, load_denied, prog_done;
  logic [15:0] flash_addr, load_data, flash_rdata;
  prog_op_t    flash_op;
  store_req_t  store_req;
  load_req_t   load_req;
  int          error_cnt, n_tests;

  cpu_core_model cpu (.clk_in(ref_clk_in), .store_out(store_req), .load_out(load_req), .flash_rdata_out(flash_rdata));

  flash_guard dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .boot_size_fuses_in(fuses), .vectors_in_boot_in(vec_boot),
    .general_lock_in(gen_lock), .chip_erase_in(chip_erase), .ext_lock_prog_in(ext_lock),
    .ext_lock_prog_we_in(ext_we), .store_in(store_req), .load_in(load_req), .flash_rdata_in(flash_rdata),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_we_in(reg_we), .reg_re_in(reg_re),
    .reg_rdata_out(reg_rdata), .cpu_halt_out(cpu_halt), .irq_mask_out(irq_mask), .flash_prog_out(flash_prog),
    .flash_op_out(flash_op), .flash_addr_out(flash_addr), .load_data_out(load_data),
    .load_valid_out(load_valid), .load_denied_out(load_denied), .prog_done_out(prog_done));

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk_in);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk_in);
    reg_re <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Arms the store enable, then issues the store two cycles later.
  task automatic store(input prog_op_t op, input logic [15:0] a, input logic [15:0] pc, input logic [3:0] lv);
    wr(`FG_REG_CTRL, 8'h01);
    cpu.do_store(op, a, pc, lv);
    #1;
  endtask

  task automatic ld(input logic [15:0] a, input logic [15:0] pc, input logic ok, input logic irq);
    cpu.do_load(a, pc);
    #1 chk({13'h0000, load_valid, load_denied, irq_mask}, {13'h0000, ok, ~ok, irq});
    chk(load_data, ok ? ~a : `FG_BLANK_WORD);
  endtask

  // Waits for completion under a bound; a run-out is a mismatch and ends the run.
  task automatic wait_done(input logic check_len);
    int n;
    n = 0;
    while (flash_prog === 1'b1 && n < 1000) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    if (check_len) chk(16'(n), 16'(`FG_OP_CYCLES));
    chk({15'h0000, prog_done}, 16'h0001);
    chk({15'h0000, cpu_halt}, 16'h0000);
    chk({15'h0000, n < 1000}, 16'h0001);
    if (n >= 1000) end_of_test();
  endtask

  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    vec_boot = 1'b0;
    chip_erase = 1'b0;
    ext_we = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    fuses = 2'h1;
    gen_lock = 2'h3; // Open (weakest) general lock level held all run; stores must still work.
    ext_lock = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(`FG_REG_STATUS, 8'h00);
    rd(`FG_REG_LOCKS, 8'h0F);
    rd(4'hF, 8'h00);
    store(OP_ERASE, 16'h1000, 16'h0100, 4'hF);
    chk({15'h0000, flash_prog}, 16'h0000);
    repeat (6) @(posedge ref_clk_in);
    // A store long after arming is the model breaking the timing on purpose.
    cpu.do_store(OP_ERASE, 16'h1000, 16'hF800, 4'hF);
    #1 chk({15'h0000, flash_prog}, 16'h0000);
    store(OP_ERASE, 16'hF900, 16'hF800, 4'hF);
    chk({14'h0000, flash_prog, cpu_halt}, 16'h0003);
    chk({flash_op, flash_addr[13:0]}, {OP_ERASE, 14'h3900});
    wait_done(1'b1);
    wr(`FG_REG_CTRL, 8'h02);
    rd(`FG_REG_STATUS, 8'h00);
    fuses <= 2'h2;
    vec_boot <= 1'b1; // Vectors sit in boot code while the concurrent region programs.
    store(OP_WRITE, 16'h1000, 16'hFC00, 4'hF);
    chk({14'h0000, flash_prog, cpu_halt}, 16'h0002);
    chk({flash_op, flash_addr[13:0]}, {OP_WRITE, 14'h1000});
    ld(16'hF100, 16'hFC00, 1'b1, 1'b0);
    ld(16'h0100, 16'hFC00, 1'b0, 1'b0);
    rd(`FG_REG_STATUS, 8'h0B);
    wait_done(1'b0);
    rd(`FG_REG_STATUS, 8'h01);
    ld(16'h0100, 16'hFC00, 1'b0, 1'b0);
    wr(`FG_REG_CTRL, 8'h02);
    ld(16'h0100, 16'hFC00, 1'b1, 1'b0);
    store(OP_LOCK_SET, 16'h0000, 16'hFC00, 4'hE);
    rd(`FG_REG_LOCKS, 8'h0E);
    store(OP_WRITE, 16'h1000, 16'hFC00, 4'hF);
    chk({15'h0000, flash_prog}, 16'h0000);
    store(OP_ERASE, 16'hFE00, 16'hFC00, 4'hF);
    chk({14'h0000, flash_prog, cpu_halt}, 16'h0003);
    wait_done(1'b0);
    // Store on the fourth edge after arming: taken, and the enable stands through the operation.
    wr(`FG_REG_CTRL, 8'h01);
    repeat (2) @(posedge ref_clk_in);
    cpu.do_store(OP_ERASE, 16'hFE00, 16'hFC00, 4'hF);
    rd(`FG_REG_STATUS, 8'h0F);
    wait_done(1'b0);
    wr(`FG_REG_CTRL, 8'h02);
    @(posedge ref_clk_in);
    chip_erase <= 1'b1;
    @(posedge ref_clk_in);
    chip_erase <= 1'b0;
    rd(`FG_REG_LOCKS, 8'h0F);
    ext_lock <= 4'h5;
    ext_we <= 1'b1;
    @(posedge ref_clk_in);
    ext_we <= 1'b0;
    rd(`FG_REG_LOCKS, 8'h05);
    vec_boot <= 1'b1;
    ld(16'h0200, 16'hFC00, 1'b0, 1'b0);
    ld(16'h0200, 16'h0100, 1'b1, 1'b1);
    ld(16'hFD00, 16'h0100, 1'b0, 1'b1);
    fuses <= 2'h3;
    ld(16'hFD00, 16'h0100, 1'b1, 1'b1);
    vec_boot <= 1'b0;
    ld(16'hFE80, 16'hFE40, 1'b1, 1'b1);
    ld(16'h0200, 16'hFE40, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
